//--- design/shader_switch_params.svh
/*
 * Constants of the shader switch control block: command decode values,
 * register sub-addresses, field positions, reset values and slot ranges.
 * Assumes it is included by bare name from the package and the design.
 */
// What this block does
// RULE1: Switch bit 0 keeps issuing ALU; bit 1 switches to texture after that slot.
// RULE2: Slots 72-95, 96-119, 120-127 map to bits of three consecutive words.
// RULE3: Sixteen check flags for r0..r15 sit in bits 8..23, r0 lowest.
// RULE4: Flag 0 skips first-destination valid check; flag 1 performs it.
// RULE5: All destination check flags reset to zero.
// RULE6: With flag set, partial ALU write waits until texture load result valid.
// RULE7: Software must set the flag when texture and ALU both first write a register.
// RULE8: Inspection register holds 16-bit flag number; bits 23:16 reserved.
// RULE9: Inspection number written with parameter type 01h at sub-address Software_inspection_flag.
// RULE10: Texture-to-ALU switch bits return issue to the ALU stream.
// RULE11: Separate ALU and texture slot counters; each stream resumes where it stopped.
// RULE12: Settings clear on reset and apply from the next program launch; the inspection flag number applies as soon as it is written.
`ifndef SHADER_SWITCH_PARAMS_SVH
`define SHADER_SWITCH_PARAMS_SVH

`define PTYPE_SHADER     8'h01
`define SUB_ALU_SW_72    8'h98
`define SUB_ALU_SW_96    8'h99
`define SUB_CHK_TAIL     8'h9A
`define SUB_INSPECT      8'hAA
`define CHK_LSB          8
`define CHK_MSB          23
`define TAIL_SW_MSB      7
`define INSPECT_MSB      15
`define WORD_RESET       24'h000000
`define CHK_RESET        16'h0000
`define LOWER_SLOTS      72
`define ALU_SLOTS        128
`define TEX_SLOTS        32

`endif

//--- design/shader_switch_pkg.sv
/*
 * Types shared by the shader switch control block.
 * Assumes the constants header is on the include path.
 */
`default_nettype none

package shader_switch_pkg;
    `include "shader_switch_params.svh"

    // One host command word: sub-address in the top byte
    typedef struct packed {
        logic [7:0]  sub_addr;
        logic [23:0] value;
    } cmd_t;

    // Program-launch copy of the loaded settings
    typedef struct packed {
        logic [`ALU_SLOTS-1:0] alu_sw;
        logic [`TEX_SLOTS-1:0] tex_sw;
        logic [15:0]           chk;
    } snap_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_ALU  = 3'h2,
        SEQ_TEX  = 3'h4
    } seq_state_t;
endpackage

`default_nettype wire

//--- design/stream_slot_counter.sv
/*
 * Slot counter for one instruction stream; wraps at its width.
 * Assumes clear and advance are single-cycle pulses in the core clock.
 */
`default_nettype none

module stream_slot_counter #(
    parameter int W = 7
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Control
    input  wire logic         clear,
    input  wire logic         advance,
    // Count
    output logic [W-1:0]      slot_ff
);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            slot_ff <= '0;
        end else if (clear) begin
            slot_ff <= '0;
        end else if (advance) begin
            slot_ff <= slot_ff + W'(1); // [RULE11]
        end
    end
endmodule

`default_nettype wire

//--- design/shader_alu_tex_switch_control.sv
/*
 * Pixel shader sequencer configuration: ALU-to-texture switch bits for
 * slots 72..127, destination check flags, inspection flag number, and the
 * issue sequencer and first-write check that use them.
 * Assumes slots 0..71 and the texture-to-ALU bits come from companion
 * register blocks, and that all inputs are synchronous to core_clk.
 */
`default_nettype none

`include "shader_switch_params.svh"

module shader_alu_tex_switch_control (
    // Clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         rstn,
    // Host command port
    input  wire logic                         cmd_valid,
    input  wire logic [7:0]                   parameter_type,
    input  wire shader_switch_pkg::cmd_t      cmd_word,
    // Host read port
    input  wire logic                         rd_en,
    input  wire logic [7:0]                   rd_addr,
    output logic [23:0]                       rd_data_ff,
    // Companion switch bits
    input  wire logic [`LOWER_SLOTS-1:0]      lower_alu_switch,
    input  wire logic [`TEX_SLOTS-1:0]        tex_to_alu_switch_bit,
    // Sequencer events
    input  wire logic                         launch,
    input  wire logic                         alu_done,
    input  wire logic                         tex_done,
    // Texture load tracking
    input  wire logic                         tex_load_issue,
    input  wire logic [3:0]                   tex_load_reg,
    input  wire logic                         tex_load_return,
    input  wire logic [3:0]                   tex_return_reg,
    // ALU destination request
    input  wire logic                         alu_req,
    input  wire logic [3:0]                   alu_dest,
    input  wire logic                         alu_partial,
    // Issue status
    output logic                              issue_tex_ff,
    output logic [6:0]                        alu_slot_ff,
    output logic [4:0]                        tex_slot_ff,
    output logic                              alu_go_ff,
    output logic                              alu_wait_ff,
    output logic [15:0]                       inspection_flag_number
);
    logic [23:0]            sw72_ff;
    logic [23:0]            sw96_ff;
    logic [23:0]            tail_ff;
    logic [15:0]            insp_ff;
    shader_switch_pkg::snap_t snap_ff;
    shader_switch_pkg::seq_state_t state_ff;
    logic [15:0]            pending_ff;
    logic [15:0]            touched_ff;
    logic                   wr_en;
    logic                   alu_adv;
    logic                   tex_adv;
    logic                   need_check;
    logic                   sw_alu_now;
    logic                   sw_tex_now;
    logic [`ALU_SLOTS-1:0]  alu_sw_all;

    assign wr_en = cmd_valid && parameter_type == `PTYPE_SHADER; // [RULE9]
    // Slot n owns bit n of the whole switch vector
    assign alu_sw_all = {tail_ff[`TAIL_SW_MSB:0], sw96_ff, sw72_ff,
                         lower_alu_switch}; // [RULE2]
    assign alu_adv    = state_ff == shader_switch_pkg::SEQ_ALU && alu_done;
    assign tex_adv    = state_ff == shader_switch_pkg::SEQ_TEX && tex_done;
    assign sw_alu_now = snap_ff.alu_sw[alu_slot_ff];
    assign sw_tex_now = snap_ff.tex_sw[tex_slot_ff];
    // Only a first partial write to a flagged, still-loading register must wait
    assign need_check = snap_ff.chk[alu_dest] && !touched_ff[alu_dest]
                        && alu_partial && pending_ff[alu_dest]; // [RULE4] [RULE6]

    // Register writes
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sw72_ff <= `WORD_RESET; // [RULE12]
            sw96_ff <= `WORD_RESET;
            tail_ff <= `WORD_RESET; // [RULE5]
            insp_ff <= 16'h0000;
        end else if (wr_en) begin
            case (cmd_word.sub_addr)
                `SUB_ALU_SW_72: sw72_ff <= cmd_word.value; // [RULE2]
                `SUB_ALU_SW_96: sw96_ff <= cmd_word.value; // [RULE2]
                `SUB_CHK_TAIL:  tail_ff <= cmd_word.value; // [RULE3]
                `SUB_INSPECT:   insp_ff <= cmd_word.value[`INSPECT_MSB:0]; // [RULE8]
                default: ;
            endcase
        end
    end

    assign inspection_flag_number = insp_ff;

    // Register reads, one cycle after rd_en; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rd_data_ff <= 24'h000000;
        end else if (rd_en) begin
            case (rd_addr)
                `SUB_ALU_SW_72: rd_data_ff <= sw72_ff;
                `SUB_ALU_SW_96: rd_data_ff <= sw96_ff;
                `SUB_CHK_TAIL:  rd_data_ff <= tail_ff;
                `SUB_INSPECT:   rd_data_ff <= {8'h00, insp_ff}; // [RULE8]
                default:        rd_data_ff <= 24'h000000;
            endcase
        end
    end

    // Switch bits and check flags are sampled at launch so a running program never sees a change
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            snap_ff <= '0;
        end else if (launch) begin
            snap_ff.alu_sw <= alu_sw_all; // [RULE12]
            snap_ff.tex_sw <= tex_to_alu_switch_bit;
            snap_ff.chk    <= tail_ff[`CHK_MSB:`CHK_LSB]; // [RULE3]
        end
    end

    // Issue sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_ff <= shader_switch_pkg::SEQ_IDLE;
        end else if (launch) begin
            state_ff <= shader_switch_pkg::SEQ_ALU;
        end else begin
            case (state_ff)
                shader_switch_pkg::SEQ_ALU: begin
                    if (alu_done && sw_alu_now) begin
                        state_ff <= shader_switch_pkg::SEQ_TEX; // [RULE1]
                    end
                end
                shader_switch_pkg::SEQ_TEX: begin
                    if (tex_done && sw_tex_now) begin
                        state_ff <= shader_switch_pkg::SEQ_ALU; // [RULE10]
                    end
                end
                shader_switch_pkg::SEQ_IDLE: state_ff <= shader_switch_pkg::SEQ_IDLE;
                default:  state_ff <= shader_switch_pkg::SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            issue_tex_ff <= 1'b0;
        end else if (launch) begin
            issue_tex_ff <= 1'b0;
        end else if (alu_adv && sw_alu_now) begin
            issue_tex_ff <= 1'b1; // [RULE1]
        end else if (tex_adv && sw_tex_now) begin
            issue_tex_ff <= 1'b0; // [RULE10]
        end
    end

    // Each stream keeps its own position across switches
    stream_slot_counter #(.W(7)) u_alu_cnt (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clear    (launch),
        .advance  (alu_adv),
        .slot_ff  (alu_slot_ff)
    ); // [RULE11]

    stream_slot_counter #(.W(5)) u_tex_cnt (
        .core_clk (core_clk),
        .rstn     (rstn),
        .clear    (launch),
        .advance  (tex_adv),
        .slot_ff  (tex_slot_ff)
    ); // [RULE11]

    // Outstanding texture loads; a new issue beats a same-cycle return
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pending_ff <= 16'h0000;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (tex_load_issue && tex_load_reg == 4'(i)) begin
                    pending_ff[i] <= 1'b1;
                end else if (tex_load_return && tex_return_reg == 4'(i)) begin
                    pending_ff[i] <= 1'b0; // [RULE6]
                end
            end
        end
    end

    // Registers already written by the ALU in this program
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            touched_ff <= 16'h0000;
        end else if (launch) begin
            touched_ff <= 16'h0000;
        end else if (alu_req && !need_check && !alu_go_ff) begin
            touched_ff[alu_dest] <= 1'b1; // [RULE4]
        end
    end

    // Grant is a pulse; requester drops alu_req after seeing it
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            alu_go_ff   <= 1'b0;
            alu_wait_ff <= 1'b0;
        end else begin
            alu_go_ff   <= alu_req && !need_check && !alu_go_ff; // [RULE6]
            alu_wait_ff <= alu_req && need_check; // [RULE6]
        end
    end

    // Checks
    switch_to_tex_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE1]
        !launch && alu_adv && sw_alu_now
        |=> issue_tex_ff && state_ff == shader_switch_pkg::SEQ_TEX)
        else $error("no switch to texture after set slot bit");

    stay_alu_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE1]
        !launch && alu_adv && !sw_alu_now |=> !issue_tex_ff)
        else $error("left ALU stream with clear bit");

    word_map_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE2]
        wr_en && cmd_word.sub_addr == `SUB_ALU_SW_96
        |=> alu_sw_all[119:96] == $past(cmd_word.value))
        else $error("slot 96-119 word not mapped");

    chk_map_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE3]
        wr_en && cmd_word.sub_addr == `SUB_CHK_TAIL ##1 launch
        |=> snap_ff.chk == $past(cmd_word.value[23:8], 2))
        else $error("check flags not at bits 23:8");

    chk_reset_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE5]
        $rose(rstn) |-> tail_ff[23:8] == 16'h0000 && snap_ff.chk == 16'h0000)
        else $error("check flags not zero after reset");

    no_check_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE4]
        alu_req && !snap_ff.chk[alu_dest] && !alu_go_ff |=> alu_go_ff && !alu_wait_ff)
        else $error("unchecked register was held");

    wait_load_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE6]
        alu_req && need_check |=> alu_wait_ff && !alu_go_ff)
        else $error("partial write not held for texture data");

    inspect_res_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE8]
        rd_en && rd_addr == `SUB_INSPECT |=> rd_data_ff[23:16] == 8'h00
        && rd_data_ff[15:0] == $past(insp_ff))
        else $error("inspection read wrong");

    inspect_type_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE9]
        cmd_valid && cmd_word.sub_addr == `SUB_INSPECT
        |=> insp_ff == ($past(parameter_type) == `PTYPE_SHADER ? $past(cmd_word.value[15:0])
                        : $past(insp_ff)))
        else $error("inspection write decode wrong");

    tex_return_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE10]
        !launch && tex_adv && sw_tex_now |=> !issue_tex_ff)
        else $error("no return to ALU stream");

    resume_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE11]
        !launch && tex_adv |=> alu_slot_ff == $past(alu_slot_ff)
        && tex_slot_ff == $past(tex_slot_ff) + 5'h1)
        else $error("stream counters not independent");

    launch_snap_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE12]
        launch |=> snap_ff.alu_sw == $past(alu_sw_all) && alu_slot_ff == 7'h00)
        else $error("settings not taken at launch");

    tail_map_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE2]
        launch |=> snap_ff.alu_sw[127:120] == $past(tail_ff[`TAIL_SW_MSB:0]))
        else $error("slot 120-127 bits not taken from the tail word");

    wrong_type_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE9]
        cmd_valid && parameter_type != `PTYPE_SHADER
        |=> $stable(sw72_ff) && $stable(sw96_ff) && $stable(tail_ff) && $stable(insp_ff))
        else $error("write taken with wrong parameter type");

    first_use_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE4]
        alu_req && touched_ff[alu_dest] && !alu_go_ff |=> alu_go_ff && !alu_wait_ff)
        else $error("register already written was held again");

    load_track_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE6]
        tex_load_issue |=> pending_ff[$past(tex_load_reg)])
        else $error("texture load not tracked as pending");

    release_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE6]
        alu_wait_ff && alu_req && !pending_ff[alu_dest] |=> alu_go_ff)
        else $error("held write not released after load data");

    // Before the first launch nothing may issue or count
    idle_hold_a: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE12]
        state_ff == shader_switch_pkg::SEQ_IDLE && !launch
        |=> !issue_tex_ff && alu_slot_ff == 7'h00)
        else $error("sequencer active before launch");

    cov_switch_c: cover property (@(posedge core_clk) disable iff (!rstn)
        alu_adv && sw_alu_now ##[1:20] tex_adv && sw_tex_now);
    cov_wait_c: cover property (@(posedge core_clk) disable iff (!rstn)
        alu_wait_ff ##[1:20] alu_go_ff);
    cov_inspect_c: cover property (@(posedge core_clk) disable iff (!rstn)
        wr_en && cmd_word.sub_addr == `SUB_INSPECT);
    cov_first_use_c: cover property (@(posedge core_clk) disable iff (!rstn)
        alu_req && touched_ff[alu_dest] && pending_ff[alu_dest] && alu_go_ff);
    cov_full_write_c: cover property (@(posedge core_clk) disable iff (!rstn)
        alu_req && !alu_partial && snap_ff.chk[alu_dest] && pending_ff[alu_dest] && alu_go_ff);
endmodule

`default_nettype wire

//--- bench/shader_alu_tex_switch_control_test.sv
/*
 * Self-checking bench for the shader ALU/texture switch control block:
 * register load and read-back, issue sequencing and first-write check.
 * Assumes the package and constants header are compiled first and that
 * the design's assertions live in the design files themselves.
 */
`default_nettype none

module shader_alu_tex_switch_control_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic                         core_clk = 1'b0;
    logic                         rstn = 1'b0;
    logic                         cmd_valid = 1'b0;
    logic [7:0]                   parameter_type = 8'h00;
    shader_switch_pkg::cmd_t      cmd_word = '0;
    logic                         rd_en = 1'b0;
    logic [7:0]                   rd_addr = 8'h00;
    logic [23:0]                  rd_data_ff;
    logic [71:0]                  lower_alu_switch = '0;
    logic [31:0]                  tex_to_alu_switch_bit = 32'h00000002;
    logic                         launch = 1'b0;
    logic                         alu_done = 1'b0;
    logic                         tex_done = 1'b0;
    logic                         tex_load_issue = 1'b0;
    logic [3:0]                   tex_load_reg = 4'h0;
    logic                         tex_load_return = 1'b0;
    logic [3:0]                   tex_return_reg = 4'h0;
    logic                         alu_req = 1'b0;
    logic [3:0]                   alu_dest = 4'h0;
    logic                         alu_partial = 1'b0;
    logic                         issue_tex_ff;
    logic [6:0]                   alu_slot_ff;
    logic [4:0]                   tex_slot_ff;
    logic                         alu_go_ff;
    logic                         alu_wait_ff;
    logic [15:0]                  inspection_flag_number;
    int                           miscompares = 0;
    int                           checked = 0;

    always #50 core_clk = ~core_clk;

    shader_alu_tex_switch_control dut (
        .core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
        .parameter_type(parameter_type), .cmd_word(cmd_word), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data_ff(rd_data_ff), .lower_alu_switch(lower_alu_switch),
        .tex_to_alu_switch_bit(tex_to_alu_switch_bit), .launch(launch),
        .alu_done(alu_done), .tex_done(tex_done), .tex_load_issue(tex_load_issue),
        .tex_load_reg(tex_load_reg), .tex_load_return(tex_load_return),
        .tex_return_reg(tex_return_reg), .alu_req(alu_req), .alu_dest(alu_dest),
        .alu_partial(alu_partial), .issue_tex_ff(issue_tex_ff), .alu_slot_ff(alu_slot_ff),
        .tex_slot_ff(tex_slot_ff), .alu_go_ff(alu_go_ff), .alu_wait_ff(alu_wait_ff),
        .inspection_flag_number(inspection_flag_number)
    );

    task automatic wrap_up();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (!(got === exp)) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] ptype, input logic [7:0] sub, input logic [23:0] val);
        @(negedge core_clk);
        cmd_valid = 1'b1;
        parameter_type = ptype;
        cmd_word = '{sub_addr: sub, value: val};
        @(negedge core_clk);
        cmd_valid = 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] addr, input logic [23:0] exp);
        @(negedge core_clk);
        rd_en = 1'b1;
        rd_addr = addr;
        @(negedge core_clk);
        rd_en = 1'b0;
        check("read word", {8'h00, exp}, {8'h00, rd_data_ff});
    endtask

    task automatic start_program();
        @(negedge core_clk);
        launch = 1'b1;
        @(negedge core_clk);
        launch = 1'b0;
    endtask

    task automatic t_reset();
        rd_check(8'h98, 24'h000000);
        rd_check(8'h99, 24'h000000);
        rd_check(8'h9A, 24'h000000);
        rd_check(8'hAA, 24'h000000);
        check("issue_tex", 32'h0, {31'h0, issue_tex_ff});
    endtask

    task automatic t_regs();
        wr(8'h01, 8'h98, 24'hA5A5A5);
        wr(8'h01, 8'h99, 24'h5A5A5A);
        wr(8'h01, 8'h9A, 24'hFFFFFF);
        wr(8'h01, 8'hAA, 24'hFF1234);
        check("flag number", 32'h1234, {16'h0, inspection_flag_number});
        rd_check(8'h98, 24'hA5A5A5);
        rd_check(8'h99, 24'h5A5A5A);
        rd_check(8'h9A, 24'hFFFFFF);
        rd_check(8'hAA, 24'h001234);
        // Wrong parameter type and unknown sub-address must leave state alone
        wr(8'h02, 8'h98, 24'h000000);
        wr(8'h01, 8'h55, 24'h123456);
        rd_check(8'h98, 24'hA5A5A5);
        rd_check(8'h55, 24'h000000);
    endtask

    task automatic t_switch();
        wr(8'h01, 8'h98, 24'h000001);
        wr(8'h01, 8'h99, 24'h000000);
        wr(8'h01, 8'h9A, 24'h000000);
        start_program();
        // Taken only at the next launch, so slot 72 must still switch
        wr(8'h01, 8'h98, 24'h000000);
        for (int i = 0; i <= 72; i++) begin
            @(negedge core_clk);
            alu_done = 1'b1;
            @(negedge core_clk);
            alu_done = 1'b0;
            check("alu slot", i + 1, {25'h0, alu_slot_ff});
            check("issue_tex", (i == 72), {31'h0, issue_tex_ff});
        end
        @(negedge core_clk);
        alu_done = 1'b1;
        @(negedge core_clk);
        alu_done = 1'b0;
        check("alu slot held", 32'd73, {25'h0, alu_slot_ff});
        for (int j = 0; j < 2; j++) begin
            @(negedge core_clk);
            tex_done = 1'b1;
            @(negedge core_clk);
            tex_done = 1'b0;
            check("tex slot", j + 1, {27'h0, tex_slot_ff});
            check("issue_tex", (j == 0), {31'h0, issue_tex_ff});
        end
    endtask

    // Load into dest, then hold a write request to it; seen is {go seen, wait seen}
    task automatic load_then_write(input logic [3:0] dest, input logic part, input int cycles,
                                   output logic [1:0] seen);
        @(negedge core_clk);
        tex_load_issue = 1'b1;
        tex_load_reg = dest;
        @(negedge core_clk);
        tex_load_issue = 1'b0;
        alu_req = 1'b1;
        alu_dest = dest;
        alu_partial = part;
        seen = 2'b00;
        for (int n = 0; n < cycles && !seen[1]; n++) begin
            @(negedge core_clk);
            seen[0] = seen[0] | (alu_wait_ff === 1'b1);
            seen[1] = (alu_go_ff === 1'b1);
        end
    endtask

    task automatic t_check();
        logic [1:0] seen;
        wr(8'h01, 8'h9A, 24'h000100);
        // Launch right behind the write so the new flags are the ones taken
        launch = 1'b1;
        @(negedge core_clk);
        launch = 1'b0;
        load_then_write(4'h0, 1'b1, 6, seen);
        check("r0 held", 32'h1, {30'h0, seen});
        tex_load_return = 1'b1;
        tex_return_reg = 4'h0;
        @(negedge core_clk);
        tex_load_return = 1'b0;
        for (int n = 0; n < 8 && !seen[1]; n++) begin
            @(negedge core_clk);
            seen[1] = (alu_go_ff === 1'b1);
        end
        alu_req = 1'b0;
        check("r0 released", 32'h1, {31'h0, seen[1]});
        if (!seen[1]) wrap_up();
        // r1 flag clear: pending load must not hold the write back
        load_then_write(4'h1, 1'b1, 3, seen);
        alu_req = 1'b0;
        check("r1 no check", 32'h2, {30'h0, seen});
        // r0 already written in this program: later writes skip the check
        load_then_write(4'h0, 1'b1, 3, seen);
        alu_req = 1'b0;
        check("r0 second write", 32'h2, {30'h0, seen});
        // Whole-register writes never wait, even on a flagged loading register
        start_program();
        load_then_write(4'h0, 1'b0, 3, seen);
        alu_req = 1'b0;
        check("r0 full write", 32'h2, {30'h0, seen});
    endtask

    initial begin
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        t_reset();
        t_regs();
        t_switch();
        t_check();
        wrap_up();
    end
endmodule

`default_nettype wire
